//--- rtl/periph_irq_ctrl.sv
// peripheral interrupt flags, enables, priorities and request routing
//
// The Avalon-MM interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ns
module periph_irq_ctrl
	import periph_irq_pkg::*;
#(
	parameter int CMP_N = 2                         // number of comparator outputs watched
) (
	input  wire logic              mclk_i,             // core clock, 100 MHz
	input  wire logic              nrst_i,             // synchronous reset, active low
	input  wire logic [ADDR_W-1:0] avs_address_i,      // byte address
	input  wire logic              avs_read_i,
	input  wire logic              avs_write_i,
	input  wire logic [31:0]       avs_writedata_i,
	input  wire logic [3:0]        avs_byteenable_i,
	output logic      [31:0]       avs_readdata_o,
	output logic                   avs_waitrequest_o,
	input  wire logic              clock_failure_i,    // pulse: fallback to internal oscillator
	input  wire logic [CMP_N-1:0]  comparator_out_i,   // asynchronous comparator levels
	input  wire logic              nv_write_done_i,    // pulse: nonvolatile write finished
	input  wire logic              serial_collision_i, // pulse: serial bus collision
	input  wire logic              voltage_above_i,    // asynchronous detector level
	input  wire logic              timer_three_overflow_i,
	input  wire logic [1:0]        capcomp_mode_i,     // capture / compare / pwm
	input  wire logic              capcomp_capture_i,  // pulse: timer capture
	input  wire logic              capcomp_match_i,    // pulse: compare match
	input  wire logic [7:0]        peripheral_flags_one_i, // first flag register, kept elsewhere
	input  wire logic              small_package_i,    // strap: parallel slave port absent
	output logic                   high_request_o,     // level to core
	output logic                   low_request_o,      // level to core
	output logic                   irq_o               // unmasked event status pending
);

	////////////////////////////////////////////////////////////////////////
	// one clock domain for every property below
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);

	////////////////////////////////////////////////////////////////////////
	// storage
	logic [7:0]       flags_two_ff;        // second flag register
	logic [7:0]       enables_one_ff;      // first enable register
	logic [7:0]       enables_two_ff;      // second enable register
	logic [7:0]       priorities_one_ff;   // first priority register
	logic [7:0]       priorities_two_ff;   // second priority register
	logic [7:0]       control_ff;          // priority enable, global enable, direction
	logic [7:0]       event_status_ff;     // sticky, write one to clear
	logic [7:0]       event_mask_ff;       // gates status onto irq_o
	logic             waitreq_ff;          // bus handshake, high when idle
	logic [31:0]      readdata_ff;
	logic             high_req_ff;
	logic             low_req_ff;
	logic             irq_ff;
	logic [CMP_N-1:0] cmp_meta_ff;         // first stage, read only by second
	logic [CMP_N-1:0] cmp_sync_ff;
	logic [CMP_N-1:0] cmp_prev_ff;
	logic             vd_meta_ff;
	logic             vd_sync_ff;
	logic             vd_prev_ff;
	logic             pkg_meta_ff;
	logic             pkg_sync_ff;

	////////////////////////////////////////////////////////////////////////
	// bus decode: a request is served on the cycle after it is first seen
	wire       bus_req    = avs_read_i | avs_write_i;
	wire       bus_acc    = bus_req & ~waitreq_ff;          // completing edge
	wire       lane0      = avs_byteenable_i[0];
	wire       acc_wr     = bus_acc & avs_write_i & lane0;  // upper lanes carry nothing
	wire [7:0] wdata      = avs_writedata_i[7:0];
	wire       wr_flags   = acc_wr & (avs_address_i == OFS_FLAGS_TWO);
	wire       wr_en_one  = acc_wr & (avs_address_i == OFS_ENABLES_ONE);
	wire       wr_en_two  = acc_wr & (avs_address_i == OFS_ENABLES_TWO);
	wire       wr_pr_one  = acc_wr & (avs_address_i == OFS_PRIORITIES_ONE);
	wire       wr_pr_two  = acc_wr & (avs_address_i == OFS_PRIORITIES_TWO);
	wire       wr_ctrl    = acc_wr & (avs_address_i == OFS_CONTROL);
	wire       wr_status  = acc_wr & (avs_address_i == OFS_EVENT_STATUS);
	wire       wr_mask    = acc_wr & (avs_address_i == OFS_EVENT_MASK);

	////////////////////////////////////////////////////////////////////////
	// control fields and package masking
	wire       prio_levels   = control_ff[CTRL_PRIO_EN_BIT];
	wire       global_en     = control_ff[CTRL_GLOBAL_EN_BIT];
	wire       vdir_rising   = control_ff[CTRL_VDIR_BIT];
	wire [7:0] pkg_mask      = pkg_sync_ff ? SMALL_PKG_MASK : FULL_MASK;
	wire [7:0] en_one_eff    = enables_one_ff & pkg_mask;
	wire [7:0] pr_one_eff    = priorities_one_ff & pkg_mask;

	////////////////////////////////////////////////////////////////////////
	// read multiplexer; unmapped addresses read zero
	logic [7:0] rd_byte;
	always_comb begin
		case (avs_address_i)
			OFS_FLAGS_TWO:      rd_byte = flags_two_ff;
			OFS_ENABLES_ONE:    rd_byte = en_one_eff;
			OFS_ENABLES_TWO:    rd_byte = enables_two_ff;
			OFS_PRIORITIES_ONE: rd_byte = pr_one_eff;
			OFS_PRIORITIES_TWO: rd_byte = priorities_two_ff;
			OFS_CONTROL:        rd_byte = control_ff;
			OFS_EVENT_STATUS:   rd_byte = event_status_ff;
			OFS_EVENT_MASK:     rd_byte = event_mask_ff;
			default:            rd_byte = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// event detection
	wire [CMP_N-1:0] cmp_diff   = cmp_sync_ff ^ cmp_prev_ff;
	wire             cmp_change = |cmp_diff;
	wire             vd_rise    = vd_sync_ff & ~vd_prev_ff;
	wire             vd_fall    = ~vd_sync_ff & vd_prev_ff;
	wire             vd_cross   = vdir_rising ? vd_rise : vd_fall;
	wire             cc_capture = (capcomp_mode_i == CC_MODE_CAPTURE) & capcomp_capture_i;
	wire             cc_compare = (capcomp_mode_i == CC_MODE_COMPARE) & capcomp_match_i;
	wire             cc_event   = cc_capture | cc_compare;

	// one bit per source; bit five never has a source
	wire [7:0] events = {clock_failure_i,
	                     cmp_change,
	                     1'b0,
	                     nv_write_done_i,
	                     serial_collision_i,
	                     vd_cross,
	                     timer_three_overflow_i,
	                     cc_event};

	////////////////////////////////////////////////////////////////////////
	// next flag values: an event in the clearing cycle still sets the flag
	// flags rise whatever the enables hold, so software may poll them
	wire [7:0] flag_base  = wr_flags ? wdata : flags_two_ff;
	wire [7:0] nxt_flags  = (flag_base | events) & IMPL_TWO;
	wire [7:0] stat_clr   = wr_status ? wdata : 8'h00;
	wire [7:0] nxt_status = ((event_status_ff & ~stat_clr) | events) & IMPL_TWO;

	////////////////////////////////////////////////////////////////////////
	// request routing
	wire [7:0] act_one  = peripheral_flags_one_i & en_one_eff;
	wire [7:0] act_two  = flags_two_ff & enables_two_ff;
	wire       hi_any   = |(act_one & pr_one_eff) | |(act_two & priorities_two_ff);
	wire       lo_any   = |(act_one & ~pr_one_eff) | |(act_two & ~priorities_two_ff);
	wire       all_any  = |act_one | |act_two;
	// compatibility mode uses the high line as the single request
	wire       nxt_high = prio_levels ? hi_any : (global_en & all_any);
	wire       nxt_low  = prio_levels & global_en & lo_any;
	wire       nxt_irq  = |(event_status_ff & event_mask_ff);

	////////////////////////////////////////////////////////////////////////
	// synchronisers for asynchronous levels and the package strap
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			cmp_meta_ff <= '0;
			cmp_sync_ff <= '0;
			cmp_prev_ff <= '0;
			vd_meta_ff  <= 1'b0;
			vd_sync_ff  <= 1'b0;
			vd_prev_ff  <= 1'b0;
			pkg_meta_ff <= 1'b0;
			pkg_sync_ff <= 1'b0;
		end else begin
			cmp_meta_ff <= comparator_out_i;
			cmp_sync_ff <= cmp_meta_ff;
			// previous copies feed the edge detectors only
			cmp_prev_ff <= cmp_sync_ff;
			vd_meta_ff  <= voltage_above_i;
			vd_sync_ff  <= vd_meta_ff;
			vd_prev_ff  <= vd_sync_ff;
			pkg_meta_ff <= small_package_i;
			pkg_sync_ff <= pkg_meta_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// avalon handshake: waitrequest drops for exactly one cycle per access
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			waitreq_ff  <= 1'b1;
			readdata_ff <= 32'h0000_0000;
		end else begin
			// one wait state: low only on the cycle after a request
			waitreq_ff  <= ~(bus_req & waitreq_ff);
			// refreshed every cycle, valid at the completing edge
			readdata_ff <= {24'h00_0000, rd_byte};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// flag and status registers
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			flags_two_ff    <= RST_FLAGS;
			event_status_ff <= RST_FLAGS;
		end else begin
			// set wins over a clearing write in the same cycle
			flags_two_ff    <= nxt_flags;
			event_status_ff <= nxt_status;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// software-owned configuration
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			enables_one_ff    <= RST_ENABLES;
			enables_two_ff    <= RST_ENABLES;
			priorities_one_ff <= RST_PRIO_ONE;
			priorities_two_ff <= RST_PRIO_TWO;
			control_ff        <= RST_CONTROL;
			event_mask_ff     <= RST_EVENT_MASK;
		end else begin
			// strap masking sits on the read and request side,
			// so the stored value survives a strap change
			if (wr_en_one) enables_one_ff <= wdata;
			if (wr_en_two) enables_two_ff <= wdata & IMPL_TWO;
			if (wr_pr_one) priorities_one_ff <= wdata;
			if (wr_pr_two) priorities_two_ff <= wdata & IMPL_TWO;
			// control keeps only its three live bits
			if (wr_ctrl) control_ff <= wdata & CTRL_IMPL;
			if (wr_mask) event_mask_ff <= wdata & IMPL_TWO;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registered outputs toward the core
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			high_req_ff <= 1'b0;
			low_req_ff  <= 1'b0;
			irq_ff      <= 1'b0;
		end else begin
			// one cycle behind flags and configuration
			high_req_ff <= nxt_high;
			low_req_ff  <= nxt_low;
			irq_ff      <= nxt_irq;
		end
	end

	// ports come straight from their flops
	assign avs_waitrequest_o = waitreq_ff;
	assign avs_readdata_o    = readdata_ff;
	assign high_request_o    = high_req_ff;
	assign low_request_o     = low_req_ff;
	assign irq_o             = irq_ff;

	////////////////////////////////////////////////////////////////////////
	// checks
	bit_five_zero_a: assert property (
		flags_two_ff[BIT_UNUSED] == 1'b0 && enables_two_ff[BIT_UNUSED] == 1'b0
		&& priorities_two_ff[BIT_UNUSED] == 1'b0)
		else $error("bit five of a second register is set");

	clock_fail_set_a: assert property (
		clock_failure_i |=> flags_two_ff[BIT_CLOCK_FAIL])
		else $error("clock failure flag not set");

	clock_fail_hold_a: assert property (
		flags_two_ff[BIT_CLOCK_FAIL] && !(wr_flags && !wdata[BIT_CLOCK_FAIL])
		|=> flags_two_ff[BIT_CLOCK_FAIL])
		else $error("clock failure flag dropped without a clearing write");

	comparator_set_a: assert property (
		$changed(cmp_sync_ff) && !$stable(cmp_sync_ff) |-> ##1 flags_two_ff[BIT_COMPARATOR])
		else $error("comparator change not flagged");

	nv_done_set_a: assert property (
		nv_write_done_i ##1 !wr_flags |=> flags_two_ff[BIT_NV_WRITE])
		else $error("write completion flag lost");

	set_over_clear_a: assert property (
		wr_flags && !wdata[BIT_COLLISION] && serial_collision_i
		|=> flags_two_ff[BIT_COLLISION])
		else $error("collision lost to a clearing write");

	voltage_dir_a: assert property (
		!flags_two_ff[BIT_VOLTAGE] && !wr_flags && !vd_cross
		|=> !flags_two_ff[BIT_VOLTAGE])
		else $error("voltage flag set without selected crossing");

	timer_three_set_a: assert property (
		timer_three_overflow_i |=> flags_two_ff[BIT_TIMER_THREE])
		else $error("timer three overflow not flagged");

	capcomp_pwm_a: assert property (
		capcomp_mode_i == CC_MODE_PWM && !flags_two_ff[BIT_CAPCOMP_TWO] && !wr_flags
		|=> !flags_two_ff[BIT_CAPCOMP_TWO])
		else $error("capture/compare flag set in pwm mode");

	single_level_gate_a: assert property (
		!prio_levels && !global_en |=> !high_request_o && !low_request_o)
		else $error("request without global enable in single level");

	low_level_gate_a: assert property (
		prio_levels && global_en && lo_any |=> low_request_o)
		else $error("low priority request not raised");

	high_route_a: assert property (
		prio_levels && (act_two & priorities_two_ff) != 8'h00 |=> high_request_o)
		else $error("high priority source not routed high");

	small_package_a: assert property (
		pkg_sync_ff && (avs_address_i == OFS_ENABLES_ONE || avs_address_i == OFS_PRIORITIES_ONE)
		|=> avs_readdata_o[BIT_PARALLEL] == 1'b0)
		else $error("parallel slave bits visible on small package");

	bus_answer_a: assert property (
		bus_req && waitreq_ff |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
		else $error("waitrequest not low for exactly one cycle");

	////////////////////////////////////////////////////////////////////////
	// holding, routing and status checks

	// untouched flags keep every set bit
	flags_hold_a: assert property (
		!wr_flags |=> (flags_two_ff & $past(flags_two_ff)) == $past(flags_two_ff))
		else $error("flag dropped without a write");

	// no completion, no flag
	nv_idle_zero_a: assert property (
		!flags_two_ff[BIT_NV_WRITE] && !nv_write_done_i && !(wr_flags && wdata[BIT_NV_WRITE])
		|=> !flags_two_ff[BIT_NV_WRITE])
		else $error("write completion flag set while pending");

	// every event lands whatever the enables hold
	events_set_a: assert property (
		|events |=> (flags_two_ff & $past(events & IMPL_TWO)) == $past(events & IMPL_TWO))
		else $error("event did not set its flag");

	// status bits clear only by a write of one
	status_hold_a: assert property (
		!wr_status |=> (event_status_ff & $past(event_status_ff)) == $past(event_status_ff))
		else $error("status bit dropped without a write");

	// status mirrors every event as a sticky bit
	status_set_a: assert property (
		|events |=> (event_status_ff & $past(events & IMPL_TWO)) == $past(events & IMPL_TWO))
		else $error("event did not set its status bit");

	// interrupt line follows masked status
	irq_level_a: assert property (
		1'b1 |=> irq_o == $past(|(event_status_ff & event_mask_ff)))
		else $error("interrupt line disagrees with masked status");

	// nothing enabled, nothing requested
	enable_gate_a: assert property (
		act_one == 8'h00 && act_two == 8'h00 |=> !high_request_o && !low_request_o)
		else $error("request from a disabled source");

	// a single level never uses the low line
	single_low_zero_a: assert property (
		!prio_levels |=> !low_request_o)
		else $error("low request in single level mode");

	// with priority levels on, low priority sources never reach the high line
	low_not_high_a: assert property (
		prio_levels && (act_one & pr_one_eff) == 8'h00 && (act_two & priorities_two_ff) == 8'h00
		|=> !high_request_o)
		else $error("high request without a high priority source");

	// single level: any enabled flag with the global gate
	single_raise_a: assert property (
		!prio_levels && global_en && (act_one | act_two) != 8'h00 |=> high_request_o)
		else $error("enabled source not requested in single level");

	// capture counts in capture mode, match in compare mode
	capture_set_a: assert property (
		capcomp_mode_i == CC_MODE_CAPTURE && capcomp_capture_i |=> flags_two_ff[BIT_CAPCOMP_TWO])
		else $error("capture not flagged");

	match_set_a: assert property (
		capcomp_mode_i == CC_MODE_COMPARE && capcomp_match_i |=> flags_two_ff[BIT_CAPCOMP_TWO])
		else $error("compare match not flagged");

	// the selected crossing always lands
	voltage_edge_a: assert property (
		(vdir_rising ? (vd_sync_ff && !vd_prev_ff) : (!vd_sync_ff && vd_prev_ff))
		|=> flags_two_ff[BIT_VOLTAGE])
		else $error("selected voltage crossing not flagged");

endmodule : periph_irq_ctrl

//--- rtl/periph_irq_pkg.sv
// constants, register map and field layout of the peripheral interrupt bookkeeping block
package periph_irq_pkg;

	////////////////////////////////////////////////////////////////////////
	// register byte addresses on the avalon slave
	localparam int          ADDR_W              = 5;
	localparam logic [4:0]  OFS_FLAGS_TWO       = 5'h00;
	localparam logic [4:0]  OFS_ENABLES_ONE     = 5'h04;
	localparam logic [4:0]  OFS_ENABLES_TWO     = 5'h08;
	localparam logic [4:0]  OFS_PRIORITIES_ONE  = 5'h0c;
	localparam logic [4:0]  OFS_PRIORITIES_TWO  = 5'h10;
	localparam logic [4:0]  OFS_CONTROL         = 5'h14;
	localparam logic [4:0]  OFS_EVENT_STATUS    = 5'h18;
	localparam logic [4:0]  OFS_EVENT_MASK      = 5'h1c;

	////////////////////////////////////////////////////////////////////////
	// bit positions of the second flag / enable / priority layout
	localparam int BIT_CLOCK_FAIL   = 7;
	localparam int BIT_COMPARATOR   = 6;
	localparam int BIT_UNUSED       = 5;
	localparam int BIT_NV_WRITE     = 4;
	localparam int BIT_COLLISION    = 3;
	localparam int BIT_VOLTAGE      = 2;
	localparam int BIT_TIMER_THREE  = 1;
	localparam int BIT_CAPCOMP_TWO  = 0;
	localparam int BIT_PARALLEL     = 7;   // parallel slave bit of the first set

	// control register fields
	localparam int CTRL_PRIO_EN_BIT   = 7;
	localparam int CTRL_GLOBAL_EN_BIT = 6;
	localparam int CTRL_VDIR_BIT      = 0;

	////////////////////////////////////////////////////////////////////////
	// reset values and implemented-bit masks
	localparam logic [7:0] RST_FLAGS        = 8'h00;
	localparam logic [7:0] RST_ENABLES      = 8'h00;
	localparam logic [7:0] RST_PRIO_ONE     = 8'hff;
	localparam logic [7:0] RST_PRIO_TWO     = 8'hdf;
	localparam logic [7:0] RST_CONTROL      = 8'h00;
	localparam logic [7:0] RST_EVENT_MASK   = 8'h00;
	localparam logic [7:0] IMPL_TWO         = 8'hdf;
	localparam logic [7:0] SMALL_PKG_MASK   = 8'h7f;
	localparam logic [7:0] FULL_MASK        = 8'hff;
	localparam logic [7:0] CTRL_IMPL        = 8'hc1;

	// capture/compare mode encodings
	localparam logic [1:0] CC_MODE_CAPTURE  = 2'h0;
	localparam logic [1:0] CC_MODE_COMPARE  = 2'h1;
	localparam logic [1:0] CC_MODE_PWM      = 2'h2;

endpackage : periph_irq_pkg

//--- test/periph_event_model.sv
// behavioural model of the peripheral modules that raise events into the block
`timescale 1ns/1ns
module periph_event_model #(
	parameter int CMP_N = 2                              // comparator outputs modelled
) (
	input  wire logic             mclk_i,                // core clock
	input  wire logic [7:0]       fire_i,                // one cycle request, flag layout
	output logic                  clock_failure_o    = 1'b0,
	output logic      [CMP_N-1:0] comparator_out_o   = '0,
	output logic                  nv_write_done_o    = 1'b0,
	output logic                  serial_collision_o = 1'b0,
	output logic                  voltage_above_o    = 1'b0,
	output logic                  timer_three_overflow_o = 1'b0,
	output logic                  capcomp_capture_o  = 1'b0,
	output logic                  capcomp_match_o    = 1'b0  // fired by bit 5, unused in layout
);
	////////////////////////////////////////////////////////////////////////
	// pulses last one cycle; levels toggle, so every request is a real change
	always @(posedge mclk_i) begin
		clock_failure_o        <= fire_i[7];
		nv_write_done_o        <= fire_i[4];
		serial_collision_o     <= fire_i[3];
		timer_three_overflow_o <= fire_i[1];
		capcomp_capture_o      <= fire_i[0];
		capcomp_match_o        <= fire_i[5];
		if (fire_i[6]) begin                             // comparator swings
			comparator_out_o <= ~comparator_out_o;
		end
		if (fire_i[2]) begin                             // supply crosses, alternating sense
			voltage_above_o <= ~voltage_above_o;
		end
	end
endmodule : periph_event_model

//--- test/tb.sv
// self-checking bench of the peripheral interrupt bookkeeping block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module tb
	import periph_irq_pkg::*;
;
	logic        mclk_i, nrst_i;                       // clock and reset
	logic [4:0]  avs_address_i = '0;                   // bus master side
	logic        avs_read_i = 1'b0, avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = '0;
	logic [3:0]  avs_byteenable_i = 4'h1;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o, high_o, low_o, irq_o;
	logic [7:0]  fire = '0, flags_one = '0;             // event requests, first flag set
	logic [1:0]  cc_mode = CC_MODE_CAPTURE;
	logic        small_pkg = 1'b0;
	logic        ev_cf, ev_nv, ev_col, ev_volt, ev_t3, ev_cap, ev_match;
	logic [1:0]  ev_cmp;
	int          err_count = 0, checks_done = 0, cycles = 0;

	periph_irq_ctrl #(.CMP_N(2)) periph_irq_ctrl_i (.mclk_i(mclk_i), .nrst_i(nrst_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.clock_failure_i(ev_cf), .comparator_out_i(ev_cmp), .nv_write_done_i(ev_nv),
		.serial_collision_i(ev_col), .voltage_above_i(ev_volt),
		.timer_three_overflow_i(ev_t3), .capcomp_mode_i(cc_mode),
		.capcomp_capture_i(ev_cap), .capcomp_match_i(ev_match),
		.peripheral_flags_one_i(flags_one), .small_package_i(small_pkg),
		.high_request_o(high_o), .low_request_o(low_o), .irq_o(irq_o));
	periph_event_model #(.CMP_N(2)) periph_event_model_i (.mclk_i(mclk_i), .fire_i(fire),
		.clock_failure_o(ev_cf), .comparator_out_o(ev_cmp), .nv_write_done_o(ev_nv),
		.serial_collision_o(ev_col), .voltage_above_o(ev_volt),
		.timer_three_overflow_o(ev_t3), .capcomp_capture_o(ev_cap),
		.capcomp_match_o(ev_match));

	////////////////////////////////////////////////////////////////////////
	// clock, and a ceiling well above the few hundred cycles the tests need
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 20000) begin                     // hang: count it and close
			err_count++;
			summarize();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus tasks: request held until waitrequest is sampled low, no cycle count assumed
	task automatic bus_write(input logic [4:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		avs_address_i   <= a;
		avs_writedata_i <= {24'h000000, d};
		avs_write_i     <= 1'b1;
		do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
		avs_write_i <= 1'b0;
	endtask : bus_write
	task automatic rd_chk(input logic [4:0] a, input logic [7:0] e, input string nm);
		logic [31:0] d;
		@(posedge mclk_i);
		avs_address_i <= a;
		avs_read_i    <= 1'b1;
		do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
		d = avs_readdata_o;                            // data taken at the completing edge
		avs_read_i <= 1'b0;
		`CHK(nm, {24'h000000, e}, d)
	endtask : rd_chk
	// one event request, then time for the two-flop synchronisers to settle
	task automatic fire_ev(input logic [7:0] m);
		@(posedge mclk_i);
		fire <= m;
		@(posedge mclk_i);
		fire <= 8'h00;
		repeat (6) @(posedge mclk_i);
	endtask : fire_ev
	// requests are registered one cycle behind the register write
	task automatic req_chk(input logic h, input logic l);
		repeat (2) @(posedge mclk_i);
		`CHK("high request", h, high_o)
		`CHK("low request", l, low_o)
	endtask : req_chk

	////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset_map;
		rd_chk(OFS_FLAGS_TWO, RST_FLAGS, "flags two reset");
		rd_chk(OFS_ENABLES_ONE, RST_ENABLES, "enables one reset");
		rd_chk(OFS_PRIORITIES_ONE, RST_PRIO_ONE, "priorities one reset");
		rd_chk(OFS_PRIORITIES_TWO, RST_PRIO_TWO, "priorities two reset");
		bus_write(OFS_FLAGS_TWO, 8'hff);
		bus_write(OFS_ENABLES_TWO, 8'hff);
		bus_write(5'h1e, 8'hff);                       // unmapped: ignored
		rd_chk(OFS_FLAGS_TWO, IMPL_TWO, "flags two bit five");
		rd_chk(OFS_ENABLES_TWO, IMPL_TWO, "enables two layout");
		rd_chk(5'h1e, 8'h00, "unmapped read");
		bus_write(OFS_FLAGS_TWO, 8'h00);
		bus_write(OFS_ENABLES_TWO, 8'h00);
		bus_write(OFS_EVENT_STATUS, 8'hff);
	endtask : t_reset_map
	// a collision in the very cycle of a clearing write must still set its flag
	task automatic t_collide;
		@(posedge mclk_i);
		fire            <= 8'h08;
		avs_address_i   <= OFS_FLAGS_TWO;
		avs_writedata_i <= 32'h0000_0000;
		avs_write_i     <= 1'b1;
		do begin
			@(posedge mclk_i);
			fire <= 8'h00;
		end while (avs_waitrequest_o !== 1'b0);
		avs_write_i <= 1'b0;
		rd_chk(OFS_FLAGS_TWO, 8'h08, "set beats clear");
		bus_write(OFS_FLAGS_TWO, 8'h00);
	endtask : t_collide
	// every source, enables all clear, so the flag must set anyway
	task automatic t_events;
		int b;
		bus_write(OFS_CONTROL, 8'h01);                 // rising crossing selected
		for (b = 0; b < 8; b++) begin
			if (b != BIT_UNUSED) begin
				fire_ev(8'(1 << b));
				rd_chk(OFS_FLAGS_TWO, 8'(1 << b), "event flag");
				bus_write(OFS_FLAGS_TWO, 8'h00);
				rd_chk(OFS_FLAGS_TWO, 8'h00, "flag cleared");
			end
		end
		fire_ev(8'h04);                                // falling crossing: not selected
		rd_chk(OFS_FLAGS_TWO, 8'h00, "wrong direction");
		bus_write(OFS_CONTROL, 8'h00);                 // falling crossing selected
		fire_ev(8'h04);
		rd_chk(OFS_FLAGS_TWO, 8'h00, "rising not selected");
		fire_ev(8'h04);
		rd_chk(OFS_FLAGS_TWO, 8'h04, "falling crossing");
		bus_write(OFS_FLAGS_TWO, 8'h00);
		cc_mode <= CC_MODE_COMPARE;
		fire_ev(8'h20);
		rd_chk(OFS_FLAGS_TWO, 8'h01, "compare match");
		bus_write(OFS_FLAGS_TWO, 8'h00);
		cc_mode <= CC_MODE_PWM;                        // neither pulse may count here
		fire_ev(8'h21);
		rd_chk(OFS_FLAGS_TWO, 8'h00, "pwm mode");
		bus_write(OFS_EVENT_STATUS, 8'hff);
	endtask : t_events
	task automatic t_requests;
		bus_write(OFS_ENABLES_TWO, 8'h02);
		bus_write(OFS_FLAGS_TWO, 8'h02);
		bus_write(OFS_CONTROL, 8'h00);
		req_chk(1'b0, 1'b0);
		bus_write(OFS_CONTROL, 8'h40);
		req_chk(1'b1, 1'b0);
		bus_write(OFS_ENABLES_TWO, 8'h00);
		req_chk(1'b0, 1'b0);
		rd_chk(OFS_FLAGS_TWO, 8'h02, "flag kept");
		bus_write(OFS_ENABLES_TWO, 8'h02);
		bus_write(OFS_PRIORITIES_TWO, 8'h00);
		bus_write(OFS_CONTROL, 8'h80);
		req_chk(1'b0, 1'b0);
		bus_write(OFS_CONTROL, 8'hc0);
		req_chk(1'b0, 1'b1);
		bus_write(OFS_PRIORITIES_TWO, 8'h02);
		bus_write(OFS_CONTROL, 8'h80);
		req_chk(1'b1, 1'b0);
		bus_write(OFS_FLAGS_TWO, 8'h00);               // cleared after service
		req_chk(1'b0, 1'b0);
	endtask : t_requests
	// first register set through the strap, priority levels still on
	task automatic t_small;
		flags_one <= 8'h80;
		small_pkg <= 1'b1;
		repeat (4) @(posedge mclk_i);
		bus_write(OFS_ENABLES_ONE, 8'hff);
		rd_chk(OFS_ENABLES_ONE, SMALL_PKG_MASK, "small enables");
		rd_chk(OFS_PRIORITIES_ONE, SMALL_PKG_MASK, "small priorities");
		req_chk(1'b0, 1'b0);
		small_pkg <= 1'b0;
		repeat (4) @(posedge mclk_i);
		req_chk(1'b1, 1'b0);
		bus_write(OFS_ENABLES_ONE, 8'h00);
		flags_one <= 8'h00;
	endtask : t_small
	task automatic t_irq;
		bus_write(OFS_EVENT_MASK, 8'h02);
		fire_ev(8'h02);
		`CHK("irq raised", 1'b1, irq_o)
		rd_chk(OFS_EVENT_STATUS, 8'h02, "status set");
		bus_write(OFS_EVENT_MASK, 8'h00);
		repeat (2) @(posedge mclk_i);
		`CHK("irq masked", 1'b0, irq_o)
		bus_write(OFS_EVENT_MASK, 8'h02);
		bus_write(OFS_EVENT_STATUS, 8'h02);
		repeat (2) @(posedge mclk_i);
		`CHK("irq cleared", 1'b0, irq_o)
	endtask : t_irq

	////////////////////////////////////////////////////////////////////////
	// verdict, reached from the main sequence or the ceiling
	task automatic summarize;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : summarize

	initial begin
		nrst_i = 1'b0;
		repeat (16) @(posedge mclk_i);
		nrst_i <= 1'b1;
		t_reset_map();
		t_collide();
		t_events();
		t_requests();
		t_small();
		t_irq();
		summarize();
	end
endmodule : tb
